// File: aft_fault_response.sv
// response logic for slowly measured faults and the start-up timeout on one channel
`timescale 1ns/1ps
`include "aft_regs.svh"
module aft_fault_response
  import aft_pkg::*;
#(
  parameter int TIME_W = 16
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_cfg_wr,
  input wire logic [2:0] i_cfg_wr_sel,
  input wire logic [7:0] i_cfg_wdata,
  input wire logic [2:0] i_cfg_rd_sel,
  input wire logic i_channel_enable_pin,
  input wire logic i_operation_on,
  input wire logic i_bias_ok,
  input wire logic i_clear_faults,
  input wire logic i_ot_fault,
  input wire logic i_ut_fault,
  input wire logic i_vin_ov_fault,
  input wire logic i_vin_uv_fault,
  input wire logic i_vout_above_uv,
  input wire logic [TIME_W-1:0] i_ton_max_limit,
  input wire logic [TIME_W-1:0] i_retry_delay,
  output logic [7:0] o_cfg_rdata,
  output logic o_channel_on,
  output logic o_host_alert_n,
  output logic [15:0] o_status_word,
  output logic [7:0] o_status_input,
  output logic [7:0] o_status_temp,
  output logic [7:0] o_status_vout,
  output logic [2:0] o_state
);

  localparam int NFLT = 5;

  function automatic logic shuts_down(input logic [7:0] cfg);
    // 01, 10 and 11 all shut down; for the timeout, 01 means a zero-length wait
    shuts_down = (cfg[`AFT_ACT_HI:`AFT_ACT_LO] != 2'h0);
  endfunction : shuts_down

  function automatic logic [2:0] retry_of(input logic [7:0] cfg);
    retry_of = cfg[`AFT_RETRY_HI:`AFT_RETRY_LO];
  endfunction : retry_of

  // configuration bytes
  logic [7:0] over_temp_response_cfg;
  logic [7:0] under_temp_response_cfg;
  logic [7:0] input_overvoltage_response_cfg;
  logic [7:0] input_undervoltage_response_cfg;
  logic [7:0] startup_timeout_response_cfg;

  // enable pin synchroniser and filtered level
  logic en_s1;
  logic en_s2;
  logic en_s3;
  logic en_filt;

  aft_state_t state;
  aft_state_t next_state;
  logic [2:0] retry_snap [NFLT];
  logic [7:0] tick_cnt;
  logic [TIME_W-1:0] retry_cnt;
  logic ton_fault;
  logic [15:0] next_status_word;
  logic [7:0] next_status_input;
  logic [7:0] next_status_temp;
  logic [7:0] next_status_vout;

  wire logic tick;
  wire logic on_request;
  wire logic running;
  wire logic [7:0] wr_byte;
  wire logic [7:0] cfg_rd_mux;
  wire logic [NFLT-1:0] flt;
  wire logic [NFLT-1:0] act_shut;
  wire logic [NFLT-1:0] shut_req;
  wire logic [NFLT-1:0] latch_req;
  wire logic fault_shut;
  wire logic fault_latch;
  wire logic retry_done;
  wire logic any_fault;

  // delay field is fixed at zero whatever is written
  assign wr_byte = {i_cfg_wdata[7:3], `AFT_DLY_FIXED};

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      over_temp_response_cfg <= `AFT_RESP_RST;
      under_temp_response_cfg <= `AFT_RESP_RST;
      input_overvoltage_response_cfg <= `AFT_RESP_RST;
      input_undervoltage_response_cfg <= `AFT_RESP_RST;
      startup_timeout_response_cfg <= `AFT_RESP_RST;
    end
    else if (i_cfg_wr)
    begin
      case (i_cfg_wr_sel)
        `AFT_SEL_OT: over_temp_response_cfg <= wr_byte;
        `AFT_SEL_UT: under_temp_response_cfg <= wr_byte;
        `AFT_SEL_VIN_OV: input_overvoltage_response_cfg <= wr_byte;
        `AFT_SEL_VIN_UV: input_undervoltage_response_cfg <= wr_byte;
        `AFT_SEL_TON: startup_timeout_response_cfg <= wr_byte;
        default: ;
      endcase
    end
  end

  assign cfg_rd_mux =
    (i_cfg_rd_sel == `AFT_SEL_OT) ? over_temp_response_cfg :
    (i_cfg_rd_sel == `AFT_SEL_UT) ? under_temp_response_cfg :
    (i_cfg_rd_sel == `AFT_SEL_VIN_OV) ? input_overvoltage_response_cfg :
    (i_cfg_rd_sel == `AFT_SEL_VIN_UV) ? input_undervoltage_response_cfg :
    (i_cfg_rd_sel == `AFT_SEL_TON) ? startup_timeout_response_cfg : 8'h00;

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      o_cfg_rdata <= 8'h00;
    else
      o_cfg_rdata <= cfg_rd_mux;
  end

  // pin crosses into the clock domain; a change counts once stages 2 and 3 agree
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      en_s1 <= 1'b0;
      en_s2 <= 1'b0;
      en_s3 <= 1'b0;
      en_filt <= 1'b0;
    end
    else
    begin
      en_s1 <= i_channel_enable_pin;
      en_s2 <= en_s1;
      en_s3 <= en_s2;
      if (en_s2 == en_s3)
        en_filt <= en_s3;
    end
  end

  // dropping any of these clears a latched state; clear_faults does not
  assign on_request = en_filt && i_operation_on && i_bias_ok;

  // 10 us time base for the start-up and retry timers
  assign tick = (tick_cnt == 8'(`AFT_TICK_CYC - 1));

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      tick_cnt <= 8'h00;
    else if (tick)
      tick_cnt <= 8'h00;
    else
      tick_cnt <= tick_cnt + 8'h01;
  end

  aft_startup_timer #(
    .LIMIT_W(TIME_W)
  ) u_startup_timer (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_start(state == AFT_START),
    .i_tick(tick),
    .i_vout_above_uv(i_vout_above_uv),
    .i_limit(i_ton_max_limit),
    .o_timeout(ton_fault)
  );

  // comparator results are already slow averages, so no sample counter here
  assign flt = {ton_fault, i_vin_uv_fault, i_vin_ov_fault, i_ut_fault, i_ot_fault};
  assign any_fault = |flt;

  assign act_shut = {shuts_down(startup_timeout_response_cfg),
                     shuts_down(input_undervoltage_response_cfg),
                     shuts_down(input_overvoltage_response_cfg),
                     shuts_down(under_temp_response_cfg),
                     shuts_down(over_temp_response_cfg)};

  // action zero only records; nonzero acts in the same cycle
  assign shut_req = flt & act_shut;

  genvar gi;
  generate
    for (gi = 0; gi < NFLT; gi++)
    begin : g_latch
      assign latch_req[gi] = shut_req[gi] && (retry_snap[gi] == 3'h0);
    end
  endgenerate

  assign running = (state == AFT_START) || (state == AFT_ON);
  assign fault_shut = running && (|shut_req);
  // if any shutting fault says latch, restarts stop
  assign fault_latch = |latch_req;
  assign retry_done = tick && (retry_cnt + TIME_W'(1) >= i_retry_delay);

  // retry settings only take hold at the next off-then-on sequence
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      for (int k = 0; k < NFLT; k++)
        retry_snap[k] <= 3'h0;
    end
    else if (state == AFT_OFF && on_request)
    begin
      retry_snap[AFT_F_OT] <= retry_of(over_temp_response_cfg);
      retry_snap[AFT_F_UT] <= retry_of(under_temp_response_cfg);
      retry_snap[AFT_F_VIN_OV] <= retry_of(input_overvoltage_response_cfg);
      retry_snap[AFT_F_VIN_UV] <= retry_of(input_undervoltage_response_cfg);
      retry_snap[AFT_F_TON] <= retry_of(startup_timeout_response_cfg);
    end
  end

  always_comb
  begin
    next_state = state;
    if (!on_request)
      next_state = AFT_OFF;
    else
    begin
      case (state)
        AFT_OFF:
          next_state = AFT_START;
        AFT_START:
        begin
          if (fault_shut)
            next_state = fault_latch ? AFT_LATCHED : AFT_RETRY;
          else if (i_vout_above_uv || ton_fault)
            next_state = AFT_ON;
        end
        AFT_ON:
        begin
          if (fault_shut)
            next_state = fault_latch ? AFT_LATCHED : AFT_RETRY;
        end
        AFT_RETRY:
        begin
          if (fault_latch)
            next_state = AFT_LATCHED;
          else if (retry_done)
            next_state = AFT_START;
        end
        AFT_LATCHED:
          next_state = AFT_LATCHED;
        default:
          next_state = AFT_OFF;
      endcase
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state <= AFT_OFF;
      retry_cnt <= '0;
    end
    else
    begin
      state <= next_state;
      if (state != AFT_RETRY)
        retry_cnt <= '0;
      else if (tick)
        retry_cnt <= retry_cnt + TIME_W'(1);
    end
  end

  // status: a new event beats a clear in the same cycle
  always_comb
  begin
    next_status_word = o_status_word & {16{!i_clear_faults}};
    next_status_input = o_status_input & {8{!i_clear_faults}};
    next_status_temp = o_status_temp & {8{!i_clear_faults}};
    next_status_vout = o_status_vout & {8{!i_clear_faults}};
    if (i_ot_fault || i_ut_fault)
      next_status_word[`AFT_SW_TEMP] = 1'b1;
    if (i_ot_fault)
      next_status_temp[`AFT_STEMP_OT] = 1'b1;
    if (i_ut_fault)
      next_status_temp[`AFT_STEMP_UT] = 1'b1;
    if (i_vin_ov_fault)
    begin
      next_status_word[`AFT_SW_INPUT] = 1'b1;
      next_status_word[`AFT_SW_HIGH_BYTE] = 1'b1;
      next_status_input[`AFT_SIN_VIN_OV] = 1'b1;
    end
    if (i_vin_uv_fault)
    begin
      next_status_word[`AFT_SW_INPUT] = 1'b1;
      next_status_word[`AFT_SW_VIN_UV] = 1'b1;
      next_status_input[`AFT_SIN_VIN_UV] = 1'b1;
    end
    if (ton_fault)
    begin
      next_status_word[`AFT_SW_VOUT] = 1'b1;
      next_status_word[`AFT_SW_HIGH_BYTE] = 1'b1;
      next_status_vout[`AFT_SVOUT_TON] = 1'b1;
    end
    // off bit is live, not sticky
    next_status_word[`AFT_SW_OFF] = (next_state != AFT_START) && (next_state != AFT_ON);
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_status_word <= 16'h0040;
      o_status_input <= 8'h00;
      o_status_temp <= 8'h00;
      o_status_vout <= 8'h00;
      o_host_alert_n <= 1'b1;
      o_channel_on <= 1'b0;
      o_state <= 3'h0;
    end
    else
    begin
      o_status_word <= next_status_word;
      o_status_input <= next_status_input;
      o_status_temp <= next_status_temp;
      o_status_vout <= next_status_vout;
      if (any_fault)
        o_host_alert_n <= 1'b0;
      else if (i_clear_faults)
        o_host_alert_n <= 1'b1;
      o_channel_on <= (next_state == AFT_START) || (next_state == AFT_ON);
      o_state <= next_state;
    end
  end

endmodule : aft_fault_response

// File: aft_regs.svh
// offsets, field positions, reset values and timing counts for the fault response block
`ifndef AFT_REGS_SVH
`define AFT_REGS_SVH

// config byte selectors on the register port
`define AFT_SEL_OT 3'h0
`define AFT_SEL_UT 3'h1
`define AFT_SEL_VIN_OV 3'h2
`define AFT_SEL_VIN_UV 3'h3
`define AFT_SEL_TON 3'h4

// response byte fields
`define AFT_ACT_HI 7
`define AFT_ACT_LO 6
`define AFT_RETRY_HI 5
`define AFT_RETRY_LO 3
`define AFT_DLY_HI 2
`define AFT_DLY_LO 0
`define AFT_DLY_FIXED 3'h0
`define AFT_RESP_RST 8'h00

// status word bit positions (low byte doubles as status byte)
`define AFT_SW_VOUT 15
`define AFT_SW_INPUT 13
`define AFT_SW_OFF 6
`define AFT_SW_VIN_UV 3
`define AFT_SW_TEMP 2
`define AFT_SW_HIGH_BYTE 0

// detailed status bit positions
`define AFT_STEMP_OT 7
`define AFT_STEMP_UT 4
`define AFT_SIN_VIN_OV 7
`define AFT_SIN_VIN_UV 4
`define AFT_SVOUT_TON 2

// timing: 10 us timer tick at 40 ns clock period
`define AFT_MCLK_NS 40
`define AFT_TICK_NS 10000
`define AFT_TICK_CYC ((`AFT_TICK_NS + `AFT_MCLK_NS - 1) / `AFT_MCLK_NS)

`endif

// File: aft_pkg.sv
// types shared by the fault response block
package aft_pkg;

  typedef enum logic [2:0] {
    AFT_OFF = 3'h0,
    AFT_START = 3'h1,
    AFT_ON = 3'h3,
    AFT_RETRY = 3'h2,
    AFT_LATCHED = 3'h6
  } aft_state_t;

  typedef enum logic [2:0] {
    AFT_F_OT = 3'h0,
    AFT_F_UT = 3'h1,
    AFT_F_VIN_OV = 3'h2,
    AFT_F_VIN_UV = 3'h3,
    AFT_F_TON = 3'h4
  } aft_fault_t;

endpackage : aft_pkg

// File: aft_startup_timer.sv
// start-up timeout timer: flags a channel that misses its undervoltage level in time
`timescale 1ns/1ps
module aft_startup_timer #(
  parameter int LIMIT_W = 16
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic i_tick,
  input wire logic i_vout_above_uv,
  input wire logic [LIMIT_W-1:0] i_limit,
  output logic o_timeout
);

  logic [LIMIT_W-1:0] cnt;
  logic fired;
  wire logic armed;
  wire logic reached;

  // a zero limit means no limit at all
  assign armed = i_start && !i_vout_above_uv && (i_limit != '0) && !fired;
  assign reached = armed && i_tick && (cnt + LIMIT_W'(1) >= i_limit);

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt <= '0;
      fired <= 1'b0;
      o_timeout <= 1'b0;
    end
    else
    begin
      o_timeout <= reached;
      if (!i_start)
      begin
        cnt <= '0;
        fired <= 1'b0;
      end
      else
      begin
        if (armed && i_tick)
          cnt <= cnt + LIMIT_W'(1);
        if (reached)
          fired <= 1'b1;
      end
    end
  end

endmodule : aft_startup_timer

// File: aft_fault_response_sva.sv
// port-level checker for the fault response block
`timescale 1ns/1ps
module aft_fault_response_sva (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_bias_ok,
  input wire logic i_operation_on,
  input wire logic i_channel_enable_pin,
  input wire logic i_clear_faults,
  input wire logic i_ot_fault,
  input wire logic i_ut_fault,
  input wire logic i_vin_ov_fault,
  input wire logic i_vin_uv_fault,
  input wire logic [7:0] o_cfg_rdata,
  input wire logic o_channel_on,
  input wire logic o_host_alert_n,
  input wire logic [15:0] o_status_word,
  input wire logic [7:0] o_status_temp,
  input wire logic [7:0] o_status_vout,
  input wire logic [2:0] o_state
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);
  wire any_flt = i_ot_fault | i_ut_fault | i_vin_ov_fault | i_vin_uv_fault;
  sequence s_req_held;
    (i_bias_ok && i_operation_on && i_channel_enable_pin) [*5];
  endsequence
  sequence s_latched;
    o_state == 3'h6;
  endsequence
  property p_dly_zero;
    o_cfg_rdata[2:0] == 3'h0;
  endproperty
  a_dly_zero: assert property (p_dly_zero) else $error("delay field reads nonzero");
  property p_alert;
    any_flt |=> !o_host_alert_n;
  endproperty
  a_alert: assert property (p_alert) else $error("alert not low after fault");
  property p_temp;
    i_ot_fault |=> o_status_temp[7] && o_status_word[2];
  endproperty
  a_temp: assert property (p_temp) else $error("temperature status not set");
  property p_vin;
    i_vin_uv_fault |=> o_status_word[3] && o_status_word[13];
  endproperty
  a_vin: assert property (p_vin) else $error("input status not set");
  property p_sticky;
    !o_host_alert_n && !i_clear_faults |=> !o_host_alert_n;
  endproperty
  a_sticky: assert property (p_sticky) else $error("alert released early");
  property p_latch;
    s_req_held ##0 s_latched |=> s_latched;
  endproperty
  a_latch: assert property (p_latch) else $error("latched state left");
  property p_bias;
    !i_bias_ok |=> o_state == 3'h0 && !o_channel_on;
  endproperty
  a_bias: assert property (p_bias) else $error("channel runs without bias");
  property p_ton;
    o_status_vout[2] |-> o_status_word[15] && o_status_word[0];
  endproperty
  a_ton: assert property (p_ton) else $error("timeout summary bits missing");
endmodule : aft_fault_response_sva

bind aft_fault_response aft_fault_response_sva u_aft_fault_response_sva (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_bias_ok(i_bias_ok), .i_operation_on(i_operation_on),
  .i_channel_enable_pin(i_channel_enable_pin), .i_clear_faults(i_clear_faults),
  .i_ot_fault(i_ot_fault), .i_ut_fault(i_ut_fault), .i_vin_ov_fault(i_vin_ov_fault),
  .i_vin_uv_fault(i_vin_uv_fault), .o_cfg_rdata(o_cfg_rdata), .o_channel_on(o_channel_on),
  .o_host_alert_n(o_host_alert_n), .o_status_word(o_status_word),
  .o_status_temp(o_status_temp), .o_status_vout(o_status_vout), .o_state(o_state)
);

// File: aft_supply_model.sv
// supply model: output passes its undervoltage level a while after enable
`timescale 1ns/1ps
module aft_supply_model #(
  parameter int RAMP = 20
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_enable,
  input wire logic i_stuck,
  output logic o_vout_above_uv
);
  int ramp_cnt;
  // stuck mimics a shorted output, the case the start-up timer guards
  always @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst || !i_enable)
    begin
      ramp_cnt <= 0;
      o_vout_above_uv <= 1'b0;
    end
    else
    begin
      if (ramp_cnt < RAMP)
        ramp_cnt <= ramp_cnt + 1;
      o_vout_above_uv <= !i_stuck && ramp_cnt >= RAMP;
    end
  end
endmodule : aft_supply_model

// File: tb.sv
// self-checking bench for the fault response block
`timescale 1ns/1ps
module tb;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic wr = 1'b0;
  logic [2:0] wsel = 3'h0;
  logic [2:0] rsel = 3'h0;
  logic [7:0] wdat = 8'h00;
  logic en = 1'b1;
  logic op = 1'b0;
  logic bias = 1'b1;
  logic clr = 1'b0;
  logic stuck = 1'b0;
  logic [3:0] flt = 4'h0;
  logic [15:0] lim = 16'h0000;
  logic [15:0] rdly = 16'h0002;
  logic above, chan_on, alert_n;
  logic [7:0] rdata, s_in, s_temp, s_vout;
  logic [15:0] sword;
  logic [2:0] state;
  int n_fail = 0;
  int num_checks = 0;
  int n;
  logic [7:0] row_wd [6] = '{8'hFF, 8'h41, 8'h9B, 8'hC7, 8'h3F, 8'hFF};
  logic [7:0] row_rd [6] = '{8'hF8, 8'h40, 8'h98, 8'hC0, 8'h38, 8'h00};
  logic [7:0] ton_cfg [3] = '{8'h00, 8'h48, 8'h80};
  logic [2:0] ton_st [3] = '{3'h3, 3'h2, 3'h6};

  initial
  begin
    forever #20 i_mclk = ~i_mclk;
  end

  aft_fault_response u_aft_fault_response (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_cfg_wr(wr), .i_cfg_wr_sel(wsel), .i_cfg_wdata(wdat),
    .i_cfg_rd_sel(rsel), .i_channel_enable_pin(en), .i_operation_on(op), .i_bias_ok(bias),
    .i_clear_faults(clr), .i_ot_fault(flt[0]), .i_ut_fault(flt[1]), .i_vin_ov_fault(flt[2]),
    .i_vin_uv_fault(flt[3]), .i_vout_above_uv(above), .i_ton_max_limit(lim),
    .i_retry_delay(rdly), .o_cfg_rdata(rdata), .o_channel_on(chan_on),
    .o_host_alert_n(alert_n), .o_status_word(sword), .o_status_input(s_in),
    .o_status_temp(s_temp), .o_status_vout(s_vout), .o_state(state)
  );
  aft_supply_model u_aft_supply_model (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_enable(chan_on), .i_stuck(stuck),
    .o_vout_above_uv(above)
  );

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wcfg(input logic [2:0] s, input logic [7:0] d);
    @(posedge i_mclk);
    wr <= 1'b1;
    wsel <= s;
    wdat <= d;
    @(posedge i_mclk);
    wr <= 1'b0;
  endtask : wcfg
  task automatic pulse(input logic [3:0] m, input logic c);
    @(posedge i_mclk);
    flt <= m;
    clr <= c;
    @(posedge i_mclk);
    flt <= 4'h0;
    clr <= 1'b0;
    @(negedge i_mclk);
  endtask : pulse
  task automatic wait_st(input logic [2:0] s, input int lim_c);
    n = 0;
    while (state !== s && n < lim_c)
    begin
      @(negedge i_mclk);
      n++;
    end
    // running out of time shows up as a wrong state
    chk(16'(state), 16'(s));
  endtask : wait_st
  task automatic set_op(input logic v);
    @(posedge i_mclk);
    op <= v;
    @(negedge i_mclk);
  endtask : set_op
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  initial
  begin
    #800000;
    n_fail++;
    stop_test();
  end

  initial
  begin
    repeat (12) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(negedge i_mclk);
    chk(sword, 16'h0040);
    chk(16'(alert_n), 16'h0001);
    for (int i = 0; i < 6; i++)
      wcfg(3'(i), row_wd[i]);
    for (int i = 0; i < 6; i++)
    begin
      @(posedge i_mclk);
      rsel <= 3'(i);
      @(posedge i_mclk);
      @(negedge i_mclk);
      chk(16'(rdata), 16'(row_rd[i]));
    end
    // continue on over-temperature, latch on under-temp, retry on input over-voltage
    wcfg(3'h0, 8'h00);
    wcfg(3'h1, 8'h40);
    wcfg(3'h2, 8'h88);
    wcfg(3'h3, 8'hC0);
    set_op(1'b1);
    wait_st(3'h3, 100);
    pulse(4'h1, 1'b0);
    chk(16'(state), 16'h0003);
    chk(16'(chan_on), 16'h0001);
    chk(16'(s_temp), 16'h0080);
    chk(sword, 16'h0004);
    repeat (5) @(negedge i_mclk);
    chk(16'(alert_n), 16'h0000);
    pulse(4'h0, 1'b1);
    chk(16'(alert_n), 16'h0001);
    pulse(4'h2, 1'b0);
    chk(16'(state), 16'h0006);
    chk(16'(chan_on), 16'h0000);
    pulse(4'h0, 1'b1);
    repeat (20) @(negedge i_mclk);
    chk(16'(state), 16'h0006);
    @(posedge i_mclk);
    en <= 1'b0;
    repeat (8) @(negedge i_mclk);
    chk(16'(state), 16'h0000);
    chk(16'(chan_on), 16'h0000);
    @(posedge i_mclk);
    en <= 1'b1;
    wait_st(3'h3, 100);
    for (int k = 0; k < 2; k++)
    begin
      pulse(4'h4, 1'b0);
      chk(16'(state), 16'h0002);
      chk(16'(chan_on), 16'h0000);
      wait_st(3'h1, 1000);
      chk(16'(n >= 250 && n <= 520), 16'h0001);
      wait_st(3'h3, 100);
    end
    // new latching setting must wait for the next off-then-on
    wcfg(3'h2, 8'h80);
    pulse(4'h4, 1'b0);
    chk(16'(state), 16'h0002);
    set_op(1'b0);
    repeat (600) @(negedge i_mclk);
    chk(16'(state), 16'h0000);
    set_op(1'b1);
    wait_st(3'h3, 100);
    pulse(4'h8, 1'b0);
    chk(16'(state), 16'h0006);
    // over-voltage bit is still held from the retry runs
    chk(16'(s_in), 16'h0090);
    chk(16'({sword[13], sword[3]}), 16'h0003);
    @(posedge i_mclk);
    bias <= 1'b0;
    @(posedge i_mclk);
    @(negedge i_mclk);
    chk(16'(state), 16'h0000);
    set_op(1'b0);
    @(posedge i_mclk);
    bias <= 1'b1;
    // shorted output at start-up, one pass per timeout response: continue, retry, latch
    lim <= 16'h0002;
    rdly <= 16'h00FF;
    stuck <= 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      wcfg(3'h4, ton_cfg[k]);
      pulse(4'h0, 1'b1);
      set_op(1'b1);
      repeat (600) @(negedge i_mclk);
      chk(16'(state), 16'(ton_st[k]));
      chk(16'(chan_on), 16'(ton_st[k] == 3'h3));
      chk(16'(s_vout), 16'h0004);
      chk(16'({sword[15], sword[0]}), 16'h0003);
      chk(16'(alert_n), 16'h0000);
      set_op(1'b0);
    end
    stop_test();
  end
endmodule : tb
